// ---- frpd_top.sv ----
// Resume, power-down and identification command handling of a serial flash
// What this block does
// - Resume only when suspended and not busy
// - Resume clears suspend, raises busy quickly
// - Resume ignored after power-lost suspend
// - Power-down needs exactly eight bits, then deselect
// - Enter power-down within entry time
// - Powered down: only release opcode recognised
// - Power-up always in normal operation
// - Release opcode wakes; commands after wake delay
// - Release plus dummies repeats device ID
// - Release opcode ignored while busy, except when powered down
// - Zero address, then maker and device ID
// - Dual width address and ID, alternating
// - Quad: dummies, address, ID four bits
// - Four dummy bytes, then 64-bit number
// - Maker, memory type, capacity bytes out
// - Suspend sets flag, drops busy
`timescale 1ns/1ns

module frpd_top
  import frpd_pkg::*;
#(
  parameter logic [7:0]  MFR_ID    = 8'h5A,                  // Arbitrary value
  parameter logic [7:0]  DEV_ID    = 8'h17,                  // Arbitrary value
  parameter logic [7:0]  MEM_TYPE  = 8'h40,                  // Arbitrary value
  parameter logic [7:0]  CAPACITY  = 8'h18,                  // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF  // Arbitrary value
)(
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  // Serial link from the host
  input  wire frpd_pkg::frpd_link_in_t  link_i,
  output frpd_pkg::frpd_link_out_t      link_o,
  // Erase/program engine
  input  wire logic                     job_start_i,
  input  wire logic                     job_done_i,
  output logic                          suspend_o,
  output logic                          resume_o,
  // Supply monitor, asynchronous
  input  wire logic                     power_lost_i,
  // Status
  output frpd_pkg::frpd_flags_t         flags_o
);
  import frpd_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;  // Reset release pipeline
  logic       rstn;        // Synchronised reset
  logic [6:0] sync1_r;     // First stage, read only by second
  logic [6:0] sync2_r;     // Second stage, safe to use
  logic [6:0] sync3_r;     // Previous value for edges

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rstn = rst_sync_r[1];

  // Two flops on every pin, a third for edge finding
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= 7'h7F;
      sync2_r <= 7'h7F;
      sync3_r <= 7'h7F;
    end
    else
    begin
      sync1_r <= {power_lost_i, link_i.cs_n, link_i.sclk, link_i.io};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Named views of the synchronised pins
  wire       pwr_lost = sync2_r[6] & ~sync3_r[6];  // Loss event
  wire       cs_n     = sync2_r[5];
  wire       cs_rise  = sync2_r[5] & ~sync3_r[5];  // Frame end
  wire       sck_rise = ~cs_n & sync2_r[4] & ~sync3_r[4];
  wire       sck_fall = ~cs_n & ~sync2_r[4] & sync3_r[4];
  wire [3:0] din      = sync2_r[3:0];

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  frpd_state_t      state_r;    // Power state
  frpd_state_t      state_nxt;
  logic [TMR_W-1:0] tmr_r;      // Power-state timer
  logic [TMR_W-1:0] tmr_nxt;
  logic [7:0]       cnt_r;      // Rising edges this frame
  logic [7:0]       op_r;       // Opcode shift register
  logic             ok_r;       // Opcode accepted
  logic             adr_nz_r;   // Nonzero address seen
  logic [7:0]       start_r;    // Edge count where output begins
  frpd_lane_t       lane_r;     // Output width
  logic [63:0]      stream_r;   // Output bits, MSB first
  logic             busy_r;     // Job running
  logic             busy_nxt;
  logic             sus_r;      // Job suspended
  logic             sus_nxt;
  logic             lost_r;     // Suspend lost to power failure
  logic             lost_nxt;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  wire [7:0] op_full  = {op_r[6:0], din[0]};
  wire       last_op  = sck_rise & (cnt_r == OPCODE_BITS - 8'h01);
  wire       in_norm  = (state_r == ST_NORMAL);
  wire       in_pdown = (state_r == ST_PDOWN);
  wire       is_rel   = (op_full == OP_RELEASE);
  wire       is_mdid  = (op_full == OP_MDID) | (op_full == OP_MDID_DUAL) | (op_full == OP_MDID_QUAD);
  wire       is_id    = is_mdid | (op_full == OP_UID) | (op_full == OP_JEDEC);
  // Reads are refused during a job; the job runs on untouched
  wire       op_norm  = in_norm & ~(busy_r & (is_rel | is_id));
  // Powered down, only the release opcode is heard
  wire       op_acc   = op_norm | (in_pdown & is_rel);

  // Stream contents and where the output phase begins
  wire [15:0] md_pair = {MFR_ID, DEV_ID};
  wire [23:0] jedec   = {MFR_ID, MEM_TYPE, CAPACITY};
  logic [63:0] load_val;
  logic [7:0]  load_start;
  frpd_lane_t  load_lane;

  // Select preload per opcode
  always_comb
  begin
    load_val   = 64'h0000_0000_0000_0000;
    load_start = 8'hFF;
    load_lane  = LANE_X1;
    case (op_full)
      OP_RELEASE:
      begin
        load_val   = {8{DEV_ID}};
        load_start = START_REL;
      end
      OP_MDID:
      begin
        load_val   = {4{md_pair}};
        load_start = START_MDID;
      end
      OP_MDID_DUAL:
      begin
        load_val   = {4{md_pair}};
        load_start = START_DUAL;
        load_lane  = LANE_X2;
      end
      OP_MDID_QUAD:
      begin
        load_val   = {4{md_pair}};
        load_start = START_QUAD;
        load_lane  = LANE_X4;
      end
      OP_UID:
      begin
        load_val   = UNIQUE_ID;
        load_start = START_UID;
      end
      OP_JEDEC:
      begin
        load_val   = {jedec, jedec, jedec[23:8]};
        load_start = START_JEDEC;
      end
      default:
      begin
        load_start = 8'hFF;  // Nothing to send
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Address check and output lanes
  // ----------------------------------------------------------------
  // Address windows per width; any set bit blocks the ID output
  wire win_x1 = (op_r == OP_MDID) & (cnt_r >= OPCODE_BITS) & (cnt_r < START_MDID);
  wire win_x2 = (op_r == OP_MDID_DUAL) & (cnt_r >= OPCODE_BITS) & (cnt_r < DUAL_ADR_END);
  wire win_x4 = (op_r == OP_MDID_QUAD) & (cnt_r >= QUAD_ADR_BEG) & (cnt_r < QUAD_ADR_END);
  wire adr_hit = (win_x1 & din[0]) | (win_x2 & |din[1:0]) | (win_x4 & |din);
  // Opcodes with nothing to send never drive, even once the count saturates
  wire out_on  = ok_r & ~adr_nz_r & (start_r != 8'hFF) & (cnt_r >= start_r);

  logic [3:0]  lanes;      // Next lane values
  logic [3:0]  lane_oe;    // Next lane enables
  logic [63:0] stream_rot; // Stream after one shift

  // Width-dependent lane mapping; single width drives the DO lane
  always_comb
  begin
    case (lane_r)
      LANE_X2:
      begin
        lanes      = {2'b00, stream_r[63:62]};
        lane_oe    = 4'b0011;
        stream_rot = {stream_r[61:0], stream_r[63:62]};
      end
      LANE_X4:
      begin
        lanes      = stream_r[63:60];
        lane_oe    = 4'b1111;
        stream_rot = {stream_r[59:0], stream_r[63:60]};
      end
      default:
      begin
        lanes      = {2'b00, stream_r[63], 1'b0};
        lane_oe    = 4'b0010;
        stream_rot = {stream_r[62:0], stream_r[63]};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  // Counts edges, shifts opcode in, data out on falling edges
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r    <= 8'h00;
      op_r     <= 8'h00;
      ok_r     <= 1'b0;
      adr_nz_r <= 1'b0;
      start_r  <= 8'hFF;
      lane_r   <= LANE_X1;
      stream_r <= 64'h0000_0000_0000_0000;
      link_o   <= '0;
    end
    else if (cs_n)
    begin
      // Deselected: clear the frame and release the lanes
      cnt_r    <= 8'h00;
      ok_r     <= 1'b0;
      adr_nz_r <= 1'b0;
      link_o   <= '0;
    end
    else
    begin
      if (sck_rise)
      begin
        // Saturate so long reads never wrap back into decode
        if (cnt_r != 8'hFF)
          cnt_r <= cnt_r + 8'h01;
        if (cnt_r < OPCODE_BITS)
          op_r <= op_full;
        if (adr_hit)
          adr_nz_r <= 1'b1;
      end
      if (last_op)
      begin
        ok_r     <= op_acc;
        start_r  <= load_start;
        lane_r   <= load_lane;
        stream_r <= load_val;
      end
      // Output changes on falling edges only
      if (sck_fall && out_on)
      begin
        link_o.io <= lanes;
        link_o.oe <= lane_oe;
        stream_r  <= stream_rot;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame-end commands
  // ----------------------------------------------------------------
  // Exactly eight bits, then deselect
  wire only_op    = cs_rise & ok_r & (cnt_r == OPCODE_BITS);
  wire end_pdown  = only_op & in_norm & (op_r == OP_PDOWN);
  wire end_resume = only_op & in_norm & (op_r == OP_RESUME) & sus_r & ~busy_r & ~lost_r;
  wire end_susp   = only_op & in_norm & (op_r == OP_SUSPEND) & ~sus_r & busy_r;
  wire end_wake   = cs_rise & ok_r & in_pdown & (op_r == OP_RELEASE) & (cnt_r >= OPCODE_BITS);
  wire wake_id    = cnt_r > OPCODE_BITS;  // ID was read too

  // ----------------------------------------------------------------
  // Power state and job flags
  // ----------------------------------------------------------------
  // Next power state and timer
  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt   = (tmr_r != '0) ? tmr_r - TMR_W'(1) : tmr_r;
    case (state_r)
      ST_NORMAL:
      begin
        if (end_pdown)
        begin
          state_nxt = ST_ENTER;
          tmr_nxt   = PD_ENTRY_CYC;
        end
      end
      ST_ENTER:
      begin
        if (tmr_r <= TMR_W'(1))
          state_nxt = ST_PDOWN;
      end
      ST_PDOWN:
      begin
        if (end_wake)
        begin
          state_nxt = ST_WAKE;
          tmr_nxt   = wake_id ? WAKE_ID_CYC : WAKE_CYC;
        end
      end
      ST_WAKE:
      begin
        // Every command is refused until the delay is over
        if (tmr_r <= TMR_W'(1))
          state_nxt = ST_NORMAL;
      end
      default:
      begin
        state_nxt = ST_NORMAL;
      end
    endcase
    // Loss of supply restarts in normal operation
    if (pwr_lost)
      state_nxt = ST_NORMAL;
  end

  // Job flags; setting events are applied last so they win
  always_comb
  begin
    busy_nxt = busy_r;
    sus_nxt  = sus_r;
    lost_nxt = lost_r;
    if (job_done_i)
      busy_nxt = 1'b0;
    if (pwr_lost)
    begin
      busy_nxt = 1'b0;
      sus_nxt  = 1'b0;
      lost_nxt = 1'b1;
    end
    if (end_resume)
    begin
      sus_nxt  = 1'b0;
      busy_nxt = 1'b1;
    end
    if (end_susp)
    begin
      sus_nxt  = 1'b1;
      busy_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
    if (job_start_i)
      busy_nxt = 1'b1;
  end

  // Power-up state is always normal operation
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_NORMAL;
      tmr_r   <= '0;
      busy_r  <= 1'b0;
      sus_r   <= 1'b0;
      lost_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
      busy_r  <= busy_nxt;
      sus_r   <= sus_nxt;
      lost_r  <= lost_nxt;
    end
  end

  // Engine pulses and status, all from flops
  always_ff @(posedge clock_i or negedge rstn)
  begin
    if (!rstn)
    begin
      suspend_o <= 1'b0;
      resume_o  <= 1'b0;
      flags_o   <= '0;
    end
    else
    begin
      suspend_o <= end_susp;
      resume_o  <= end_resume;
      flags_o   <= '{busy: busy_nxt, suspend_flag: sus_nxt, powerdown: (state_nxt == ST_PDOWN)};
    end
  end

endmodule : frpd_top

// ---- frpd_pkg.sv ----
// Shared constants and types of the resume, power-down and identification command block
package frpd_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RESUME    = 8'h7A;  // Resume suspended job
  localparam logic [7:0] OP_SUSPEND   = 8'h75;  // Suspend running job
  localparam logic [7:0] OP_PDOWN     = 8'hB9;  // Enter power-down
  localparam logic [7:0] OP_RELEASE   = 8'hAB;  // Release / device ID
  localparam logic [7:0] OP_MDID      = 8'h90;  // Maker and device ID
  localparam logic [7:0] OP_MDID_DUAL = 8'h92;  // Same, two lanes
  localparam logic [7:0] OP_MDID_QUAD = 8'h94;  // Same, four lanes
  localparam logic [7:0] OP_UID       = 8'h4B;  // 64-bit unique number
  localparam logic [7:0] OP_JEDEC     = 8'h9F;  // Three-byte identity

  // ----------------------------------------------------------------
  // Frame positions, counted in rising serial clock edges
  // ----------------------------------------------------------------
  localparam logic [7:0] OPCODE_BITS = 8'h08;  // Opcode length
  localparam logic [7:0] START_REL   = 8'h20;  // Opcode + 3 dummy bytes
  localparam logic [7:0] START_MDID  = 8'h20;  // Opcode + 24-bit address
  localparam logic [7:0] START_DUAL  = 8'h18;  // Opcode + 12 addr + 4 mode
  localparam logic [7:0] START_QUAD  = 8'h14;  // Opcode + 4 dummy + 6 addr + 2 mode
  localparam logic [7:0] START_UID   = 8'h28;  // Opcode + 4 dummy bytes
  localparam logic [7:0] START_JEDEC = 8'h08;  // Data follows the opcode
  localparam logic [7:0] DUAL_ADR_END = 8'h14;  // Dual address ends here
  localparam logic [7:0] QUAD_ADR_BEG = 8'h0C;  // Quad address starts here
  localparam logic [7:0] QUAD_ADR_END = 8'h12;  // Quad address ends here

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS           = 10;
  localparam int unsigned POWERDOWN_ENTRY_TIME_NS = 3000;
  localparam int unsigned WAKE_DELAY_NS           = 3000;
  localparam int unsigned WAKE_WITH_ID_DELAY_NS   = 1800;
  localparam int unsigned TMR_W                   = 16;
  // Longest times, so round down
  localparam logic [TMR_W-1:0] PD_ENTRY_CYC = TMR_W'(POWERDOWN_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] WAKE_CYC     = TMR_W'(WAKE_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] WAKE_ID_CYC  = TMR_W'(WAKE_WITH_ID_DELAY_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_ENTER  = 4'b0010,
    ST_PDOWN  = 4'b0100,
    ST_WAKE   = 4'b1000
  } frpd_state_t;

  typedef enum logic [2:0] {
    LANE_X1 = 3'b001,
    LANE_X2 = 3'b010,
    LANE_X4 = 3'b100
  } frpd_lane_t;

  typedef struct packed {
    logic       cs_n;  // Chip select, low active
    logic       sclk;  // Serial clock
    logic [3:0] io;    // Data lanes in
  } frpd_link_in_t;

  typedef struct packed {
    logic [3:0] io;    // Data lanes out
    logic [3:0] oe;    // Lane drive enables
  } frpd_link_out_t;

  typedef struct packed {
    logic busy;          // Job running
    logic suspend_flag;  // Job suspended
    logic powerdown;     // Deep power-down
  } frpd_flags_t;

endpackage : frpd_pkg

// ---- frpd_top_assertions.sv ----
// Port-level checker of the resume, power-down and identification block
`timescale 1ns/1ns

module frpd_top_assertions
  import frpd_pkg::*;
(
  // Clock and reset
  input wire logic                     clock_i,
  input wire logic                     rstn_i,
  // Serial link
  input wire frpd_pkg::frpd_link_in_t  link_i,
  input wire frpd_pkg::frpd_link_out_t link_o,
  // Engine, supply and status
  input wire logic                     job_start_i,
  input wire logic                     job_done_i,
  input wire logic                     suspend_o,
  input wire logic                     resume_o,
  input wire logic                     power_lost_i,
  input wire frpd_pkg::frpd_flags_t    flags_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] cs_hi_r;    // Cycles with select high, saturating
  logic [7:0] cs_hi_nxt;  // Next count
  // Saturate so a long idle never wraps back to a small count
  assign cs_hi_nxt = link_i.cs_n ? ((cs_hi_r == 8'hFF) ? cs_hi_r : cs_hi_r + 8'h01) : 8'h00;
  // Count register
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i) cs_hi_r <= 8'h00;
    else cs_hi_r <= cs_hi_nxt;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_resume_needs_suspend: assert property (resume_o |-> $past(flags_o.suspend_flag) && !$past(flags_o.busy))
    else $error("resume accepted without a suspended idle job");
  a_resume_flag_effect: assert property (resume_o |-> ##[0:1] (!flags_o.suspend_flag && flags_o.busy))
    else $error("resume did not clear suspend and raise busy");
  a_busy_rise_cause: assert property ($rose(flags_o.busy) |->
    ($past(job_start_i) || $past(job_start_i, 2) || resume_o || $past(resume_o)))
    else $error("busy rose without a job start or resume");
  a_suspend_needs_busy: assert property (suspend_o |-> $past(flags_o.busy) && !$past(flags_o.suspend_flag))
    else $error("suspend accepted while idle or already suspended");
  a_suspend_flag_effect: assert property (suspend_o |-> ##[0:1] (flags_o.suspend_flag && !flags_o.busy))
    else $error("suspend did not set its flag and drop busy");
  a_pdown_single_lane: assert property (flags_o.powerdown |-> link_o.oe inside {4'h0, 4'h2})
    else $error("multi-lane output while powered down");
  a_pdown_exit_frame: assert property ($fell(flags_o.powerdown) |-> link_i.cs_n)
    else $error("power-down left while select low");
  a_oe_after_deselect: assert property (cs_hi_r >= 8'h08 |-> link_o.oe == 4'h0)
    else $error("lanes still driven long after deselect");
  a_oe_lane_codes: assert property (link_o.oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
endmodule : frpd_top_assertions

bind frpd_top frpd_top_assertions u_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .link_i(link_i), .link_o(link_o),
  .job_start_i(job_start_i), .job_done_i(job_done_i), .suspend_o(suspend_o),
  .resume_o(resume_o), .power_lost_i(power_lost_i), .flags_o(flags_o)
);

// ---- frpd_host_model.sv ----
// Behavioural host controller that drives select, clock and lanes
`timescale 1ns/1ns

module frpd_host_model
  import frpd_pkg::*;
(
  // Clock
  input  wire logic                     clock_i,
  // Link
  input  wire frpd_pkg::frpd_link_out_t link_i,
  output frpd_pkg::frpd_link_in_t       link_o
);
  logic       cs_n_r = 1'b1;    // Select, idle high
  logic       sclk_r = 1'b1;    // Clock idles high, stops between frames
  logic       drv_r  = 1'b0;    // Host drives lanes
  logic [3:0] io_r   = 4'h0;    // Host lane values
  logic [3:0] flt_r  = 4'h5;    // Released lanes wander, never hold a value

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  always @(posedge clock_i) flt_r <= ~flt_r;
  assign link_o.cs_n = cs_n_r;
  assign link_o.sclk = sclk_r;
  // Each lane carries the device, the host or a floating pattern
  assign link_o.io = (link_i.oe & link_i.io) | (~link_i.oe & (drv_r ? io_r : flt_r));

  // ----------------------------------------------------------------
  // Frame tasks, entered at a falling clock_i edge
  // ----------------------------------------------------------------
  task automatic frame_start();
    cs_n_r = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask : frame_start

  // Select rises right after the last clock, even mid-byte
  task automatic frame_end(input int gap);
    drv_r = 1'b0;
    cs_n_r = 1'b1;
    repeat (gap) @(negedge clock_i);
  endtask : frame_end

  // Bits leave MSB first, w lanes per clock; data read late in the high phase
  task automatic shift(input logic [63:0] v, input int n, input int w, input logic drive,
                       output logic [63:0] rx, output logic [3:0] oe);
    logic [63:0] sh;
    sh = v;
    rx = 64'h0;
    oe = 4'h0;
    for (int i = 0; i < n; i++)
    begin
      sclk_r = 1'b0;
      drv_r = drive;
      io_r = 4'(sh >> (64 - w));
      sh = sh << w;
      repeat (4) @(negedge clock_i);
      sclk_r = 1'b1;
      repeat (4) @(negedge clock_i);
      rx = (w == 1) ? {rx[62:0], link_o.io[1]} : (w == 2) ? {rx[61:0], link_o.io[1:0]} : {rx[59:0], link_o.io};
      oe = link_i.oe;
    end
  endtask : shift
endmodule : frpd_host_model

// ---- frpd_top_bench.sv ----
// Self-checking bench of the resume, power-down and identification block
`timescale 1ns/1ns

module frpd_top_bench;
  import frpd_pkg::*;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam logic [7:0]  MFR = 8'hC3;                  // Arbitrary value
  localparam logic [7:0]  DEV = 8'h3C;                  // Arbitrary value
  localparam logic [7:0]  MEM = 8'h60;                  // Arbitrary value
  localparam logic [7:0]  CAP = 8'h19;                  // Arbitrary value
  localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210; // Arbitrary value
  localparam int          GUARD = 100;                  // Resume-to-suspend spacing
  localparam int          LIMIT = 60000;                // Hang ceiling
  typedef struct packed {
    logic [7:0] op; logic [63:0] pre; logic [7:0] pn; logic [2:0] pw;
    logic [7:0] rn; logic [2:0] rw; logic [63:0] exp; logic [3:0] oe;
  } frpd_row_t;
  logic           clock_i, rstn_i, job_start_i, job_done_i, power_lost_i, suspend_o, resume_o;
  frpd_link_in_t  link_i;
  frpd_link_out_t link_o;
  frpd_flags_t    flags_o;
  int             failures, total_checks, cyc, n_res;
  logic [63:0]    rx;
  logic [3:0]     oe;
  frpd_row_t      rows [6];

  frpd_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP), .UNIQUE_ID(UID)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .link_i(link_i), .link_o(link_o),
    .job_start_i(job_start_i), .job_done_i(job_done_i), .suspend_o(suspend_o),
    .resume_o(resume_o), .power_lost_i(power_lost_i), .flags_o(flags_o));
  frpd_host_model host (.clock_i(clock_i), .link_i(link_o), .link_o(link_i));

  // ----------------------------------------------------------------
  // Clock, pulse counter and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (resume_o === 1'b1) n_res <= n_res + 1;
    if (cyc == LIMIT)
    begin
      failures = failures + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // One whole frame: opcode, lead-in bits, read phase
  task automatic cmd(input logic [7:0] op, input logic [63:0] pre, input int pn, input int pw,
                     input int rn, input int rw);
    host.frame_start();
    host.shift({op, 56'h0}, 8, 1, 1'b1, rx, oe);
    if (pn > 0) host.shift(pre, pn, pw, 1'b1, rx, oe);
    if (rn > 0) host.shift(64'h0, rn, rw, 1'b0, rx, oe);
    host.frame_end(8);
  endtask : cmd

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rstn_i, job_start_i, job_done_i, power_lost_i} = 4'h0;
    {failures, total_checks, cyc, n_res} = '0;
    rows[0] = '{OP_JEDEC, 64'h0, 8'h00, 3'h1, 8'h18, 3'h1, {40'h0, MFR, MEM, CAP}, 4'h2};
    rows[1] = '{OP_MDID, 64'h0, 8'h18, 3'h1, 8'h20, 3'h1, {32'h0, MFR, DEV, MFR, DEV}, 4'h2};
    rows[2] = '{OP_MDID_DUAL, 64'h0000_00F0_0000_0000, 8'h10, 3'h2, 8'h10, 3'h2, {32'h0, MFR, DEV, MFR, DEV}, 4'h3};
    rows[3] = '{OP_MDID_QUAD, 64'h0000_0000_00F0_0000, 8'h0C, 3'h4, 8'h08, 3'h4, {32'h0, MFR, DEV, MFR, DEV}, 4'hF};
    rows[4] = '{OP_RELEASE, 64'h0, 8'h18, 3'h1, 8'h10, 3'h1, {48'h0, DEV, DEV}, 4'h2};
    rows[5] = '{OP_UID, 64'h0, 8'h20, 3'h1, 8'h40, 3'h1, UID, 4'h2};
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    check(64'(flags_o), 64'h0);
    repeat (10) @(negedge clock_i);
    // Identification reads, every width
    for (int i = 0; i < 6; i++)
    begin
      cmd(rows[i].op, rows[i].pre, int'(rows[i].pn), int'(rows[i].pw), int'(rows[i].rn), int'(rows[i].rw));
      check(rx, rows[i].exp);
      check(64'(oe), 64'(rows[i].oe));
    end
    // A nonzero address bit silences the read
    cmd(OP_MDID, 64'h0000_0100_0000_0000, 24, 1, 8, 1);
    check(64'(oe), 64'h0);
    // Resume refused while busy, release refused while busy
    job_start_i = 1'b1;
    @(negedge clock_i);
    job_start_i = 1'b0;
    cmd(OP_RESUME, 64'h0, 0, 1, 0, 1);
    check(64'(n_res), 64'h0);
    cmd(OP_RELEASE, 64'h0, 24, 1, 8, 1);
    check(64'(oe), 64'h0);
    check(64'(flags_o), 64'h4);
    // Suspend, then resume
    cmd(OP_SUSPEND, 64'h0, 0, 1, 0, 1);
    check(64'(flags_o), 64'h2);
    cmd(OP_RESUME, 64'h0, 0, 1, 0, 1);
    check(64'(flags_o), 64'h4);
    check(64'(n_res), 64'h1);
    repeat (GUARD) @(negedge clock_i);
    // Power lost during suspend: resume must be ignored
    cmd(OP_SUSPEND, 64'h0, 0, 1, 0, 1);
    power_lost_i = 1'b1;
    repeat (4) @(negedge clock_i);
    power_lost_i = 1'b0;
    repeat (4) @(negedge clock_i);
    cmd(OP_RESUME, 64'h0, 0, 1, 0, 1);
    check(64'(n_res), 64'h1);
    check(64'(flags_o), 64'h0);
    // Nine bits is not a power-down
    host.frame_start();
    host.shift({OP_PDOWN, 56'h0}, 9, 1, 1'b1, rx, oe);
    host.frame_end(int'(PD_ENTRY_CYC) + 20);
    check(64'(flags_o.powerdown), 64'h0);
    cmd(OP_PDOWN, 64'h0, 0, 1, 0, 1);
    repeat (int'(PD_ENTRY_CYC) + 20) @(negedge clock_i);
    check(64'(flags_o.powerdown), 64'h1);
    cmd(OP_JEDEC, 64'h0, 0, 1, 8, 1);
    check(64'(oe), 64'h0);
    // Release, a refused read inside the wake delay, then a good one
    cmd(OP_RELEASE, 64'h0, 0, 1, 0, 1);
    check(64'(flags_o.powerdown), 64'h0);
    cmd(OP_JEDEC, 64'h0, 0, 1, 8, 1);
    check(64'(oe), 64'h0);
    repeat (int'(WAKE_CYC) + 20) @(negedge clock_i);
    cmd(OP_JEDEC, 64'h0, 0, 1, 24, 1);
    check(rx, {40'h0, MFR, MEM, CAP});
    // Power-down, then release with an ID read and the shorter wait
    cmd(OP_PDOWN, 64'h0, 0, 1, 0, 1);
    repeat (int'(PD_ENTRY_CYC) + 20) @(negedge clock_i);
    cmd(OP_RELEASE, 64'h0, 24, 1, 8, 1);
    check(rx, {56'h0, DEV});
    repeat (int'(WAKE_ID_CYC) + 20) @(negedge clock_i);
    cmd(OP_JEDEC, 64'h0, 0, 1, 24, 1);
    check(rx, {40'h0, MFR, MEM, CAP});
    // Reset while powered down comes back in normal operation
    cmd(OP_PDOWN, 64'h0, 0, 1, 0, 1);
    repeat (int'(PD_ENTRY_CYC) + 20) @(negedge clock_i);
    rstn_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check(64'(flags_o), 64'h0);
    rstn_i = 1'b1;
    repeat (10) @(negedge clock_i);
    cmd(OP_JEDEC, 64'h0, 0, 1, 24, 1);
    check(rx, {40'h0, MFR, MEM, CAP});
    finish_test();
  end
endmodule : frpd_top_bench
